// ---- inc/bmsl_pkg.sv ----
// Purpose: Shared constants and types for the boot mode select loader.
// Assumes: One 40 MHz core clock, synchronous active-high reset.
// Notes: Addresses are 14-bit device addresses.
package bmsl_pkg;
  typedef enum logic [2:0] {
    BMSL_SINGLE, BMSL_RAM_JUMP, BMSL_RAM_LOAD, BMSL_EP_VERIFY, BMSL_EP_PROGRAM
  } bmsl_mode_t;
  localparam int BMSL_AW = 14;
  localparam logic [13:0] BMSL_RAM_ENTRY = 14'h0081;
  localparam logic [13:0] BMSL_RAM_BASE = 14'h0080;
  localparam logic [13:0] BMSL_PV_SWI = 14'h0083;
  localparam logic [13:0] BMSL_PV_IRQ = 14'h0086;
  localparam logic [13:0] BMSL_PV_CTIMER = 14'h0089;
  localparam logic [13:0] BMSL_PV_I2C = 14'h008C;
  localparam logic [13:0] BMSL_PV_PTIMER = 14'h008F;
  localparam logic [13:0] BMSL_LDR_VEC_LO = 14'h3FE4;
  localparam logic [13:0] BMSL_LDR_VEC_HI = 14'h3FEF;
  localparam logic [13:0] BMSL_EP_FIRST = 14'h0000;
  localparam logic [13:0] BMSL_EP_LAST = 14'h3FFF;
  localparam logic [7:0] BMSL_MAX_IMAGE = 8'hFE;
  localparam logic [7:0] BMSL_JMP_OPCODE = 8'hCC;
  localparam int BMSL_CLK_HZ = 40000000;
  localparam int BMSL_BAUD = 9600;
  localparam int BMSL_BIT_CYC = BMSL_CLK_HZ / BMSL_BAUD;
  localparam int BMSL_HALF_CYC = BMSL_BIT_CYC / 2;
endpackage : bmsl_pkg

// ---- verilog/bmsl_uart_rx.sv ----
// Purpose: Serial byte receiver for the RAM download, 8N1, LSB first.
// Assumes: Line idles high; input synchronous to core_clk.
// Notes: Start bit is rechecked at mid-bit to reject glitches.
`timescale 1ns/1ps
module bmsl_uart_rx #(
  parameter int BIT_CYC = bmsl_pkg::BMSL_BIT_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Line
  input wire logic rx_line,
  // Byte out
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_frame_err
);
  import bmsl_pkg::*;
  typedef enum logic [1:0] {BMSL_RX_IDLE, BMSL_RX_START, BMSL_RX_DATA, BMSL_RX_STOP} bmsl_rx_t;
  bmsl_rx_t st_q;
  logic [15:0] cnt_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;

  // Bit timing and shift; samples are taken at the middle of each bit.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= BMSL_RX_IDLE;
      cnt_q <= 16'h0000;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_frame_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      case (st_q)
        BMSL_RX_IDLE: begin
          cnt_q <= 16'h0000;
          if (!rx_line) st_q <= BMSL_RX_START;
        end
        BMSL_RX_START: begin
          if (cnt_q == 16'(BIT_CYC / 2)) begin
            cnt_q <= 16'h0000;
            bit_q <= 3'h0;
            st_q <= rx_line ? BMSL_RX_IDLE : BMSL_RX_DATA;
          end else cnt_q <= cnt_q + 16'h0001;
        end
        BMSL_RX_DATA: begin
          if (cnt_q == 16'(BIT_CYC - 1)) begin
            cnt_q <= 16'h0000;
            sh_q <= {rx_line, sh_q[7:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) st_q <= BMSL_RX_STOP;
          end else cnt_q <= cnt_q + 16'h0001;
        end
        BMSL_RX_STOP: begin
          if (cnt_q == 16'(BIT_CYC - 1)) begin
            st_q <= BMSL_RX_IDLE;
            rx_valid <= rx_line;
            rx_data <= sh_q;
            rx_frame_err <= !rx_line;
          end else cnt_q <= cnt_q + 16'h0001;
        end
        default: st_q <= BMSL_RX_IDLE;
      endcase
    end
  end
endmodule : bmsl_uart_rx

// ---- verilog/bmsl_buf2.sv ----
// Purpose: Two-entry valid/ready buffer in the download data path.
// Assumes: Single clock.
// Notes: in_ready drops only when both entries hold words.
`timescale 1ns/1ps
module bmsl_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [$clog2(DEPTH)-1:0] wp_q, rp_q;
  logic [$clog2(DEPTH):0] cnt_q;
  logic push, pop;

  // Honest full and empty come straight from the occupancy count.
  assign in_ready = (cnt_q != ($clog2(DEPTH)+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
    end
  end

  // Storage is written only; no reset needed on data.
  always_ff @(posedge core_clk) begin
    if (push) mem_q[wp_q] <= in_data;
  end
endmodule : bmsl_buf2

// ---- verilog/bmsl_loader.sv ----
// Purpose: Boot mode selection at reset release and the RAM and EPROM loaders.
// Assumes: Mode pins are presented as decoded levels synchronous to core_clk.
// Notes: The EPROM loader is a hardware sequencer standing in for the boot code.
// Functional notes
// - Mode is latched at reset release; normal-level mode pin gives single chip.
// - Bootloader needs high-voltage pin and guard pin; loader-kind high picks RAM loader.
// - RAM loader with action low jumps to RAM address 0081.
// - RAM loader with action high downloads serially, then starts at 0081.
// - Image including count byte is at most 254 bytes.
// - Serial format 9600 baud, 8 data, no parity, 1 start, 1 stop.
// - In RAM loader modes interrupts go to three-byte RAM pseudo-vectors.
// - Pseudo-vectors at 0083, 0086, 0089, 008C and 008F.
// - EPROM loader takes vectors from reserved ROM 3FE4 to 3FEF.
// - Device clocks and resets external 14-bit counter in lockstep.
// - Full programming pass, then full verify pass against external memory.
// - Loader-kind low: action low verifies only, high programs then verifies.
// - Program lamp during programming; verify lamp only if all bytes match.
// - In single chip, EPROM variant fetches all vectors from user EPROM; the code reads 3FE4 to 3FEC, the loader ROM slots.
`timescale 1ns/1ps
module bmsl_loader #(
  parameter int BIT_CYC = bmsl_pkg::BMSL_BIT_CYC,
  parameter logic [13:0] EP_LAST = bmsl_pkg::BMSL_EP_LAST
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Mode straps
  input wire logic high_voltage_mode_pin,
  input wire logic mode_guard_pin,
  input wire logic loader_kind_pin,
  input wire logic loader_action_pin,
  // Serial download
  input wire logic serial_load_input,
  // RAM write port
  output logic ram_we,
  output logic [13:0] ram_addr,
  output logic [7:0] ram_wdata,
  // Core start
  output logic core_start,
  output logic [13:0] core_pc,
  output bmsl_pkg::bmsl_mode_t mode,
  // Interrupt vector redirection
  input wire logic [2:0] irq_src,
  output logic [13:0] vec_addr,
  output logic vec_in_ram,
  // External counter
  output logic ext_cnt_clk,
  output logic ext_cnt_rst,
  input wire logic [7:0] ext_data,
  // On-chip EPROM
  output logic ep_we,
  output logic [13:0] ep_addr,
  output logic [7:0] ep_wdata,
  input wire logic [7:0] ep_rdata,
  // Lamps
  output logic programming_lamp,
  output logic verify_lamp,
  output logic load_error
);
  import bmsl_pkg::*;
  typedef enum logic [3:0] {
    BMSL_S_SEL, BMSL_S_RUN, BMSL_S_DL, BMSL_S_XRST, BMSL_S_PROGRAMMING_LAMP, BMSL_S_VRST,
    BMSL_S_VER, BMSL_S_DONE
  } bmsl_state_t;

  bmsl_state_t st_q;
  logic sel_q;
  logic [13:0] addr_q;
  logic [7:0] left_q;
  logic first_q;
  logic ok_q;
  logic ph_q;
  // Counter clock phase; its high half marks the address step.
  logic cclk_q;
  logic ph_programming_lamp_adv;
  logic [2:0] src_idx;
  logic rx_v, rx_err, b_v, b_r;
  logic [7:0] rx_d, b_d;

  // Receiver and two-entry buffer; the buffer absorbs a word while RAM is busy.
  bmsl_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .core_clk(core_clk),
    .rst(rst),
    .rx_line(serial_load_input),
    .rx_valid(rx_v),
    .rx_data(rx_d),
    .rx_frame_err(rx_err)
  );
  bmsl_buf2 #(.WIDTH(8), .DEPTH(2)) u_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(rx_v && st_q == BMSL_S_DL),
    .in_ready(),
    .in_data(rx_d),
    .out_valid(b_v),
    .out_ready(b_r),
    .out_data(b_d)
  );
  // Drain one word each other cycle so the RAM write slot alternates.
  assign b_r = (st_q == BMSL_S_DL) && !ph_q;

  // Mode is taken in the first cycle after reset release, never under reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_q <= 1'b0;
      mode <= BMSL_SINGLE;
    end else if (!sel_q) begin
      sel_q <= 1'b1;
      if (!high_voltage_mode_pin || !mode_guard_pin) mode <= BMSL_SINGLE;
      else if (loader_kind_pin) mode <= loader_action_pin ? BMSL_RAM_LOAD : BMSL_RAM_JUMP;
      else mode <= loader_action_pin ? BMSL_EP_PROGRAM : BMSL_EP_VERIFY;
    end
  end

  // Write-slot phase toggle for the download path.
  always_ff @(posedge core_clk) begin
    if (rst) ph_q <= 1'b0;
    else ph_q <= (st_q == BMSL_S_DL) ? !ph_q : 1'b0;
  end

  // Main sequencer for both loaders.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= BMSL_S_SEL;
      addr_q <= 14'h0000;
      left_q <= 8'h00;
      first_q <= 1'b1;
      ok_q <= 1'b1;
      core_start <= 1'b0;
      core_pc <= 14'h0000;
      load_error <= 1'b0;
    end else begin
      core_start <= 1'b0;
      case (st_q)
        BMSL_S_SEL: begin
          if (sel_q) begin
            case (mode)
              BMSL_RAM_JUMP: begin
                core_pc <= BMSL_RAM_ENTRY;
                core_start <= 1'b1;
                st_q <= BMSL_S_RUN;
              end
              BMSL_RAM_LOAD: begin
                addr_q <= BMSL_RAM_BASE;
                first_q <= 1'b1;
                st_q <= BMSL_S_DL;
              end
              BMSL_EP_PROGRAM: st_q <= BMSL_S_XRST;
              BMSL_EP_VERIFY: st_q <= BMSL_S_VRST;
              default: begin
                core_pc <= BMSL_EP_FIRST;
                core_start <= 1'b1;
                st_q <= BMSL_S_RUN;
              end
            endcase
          end
        end
        BMSL_S_DL: begin
          if (rx_err) load_error <= 1'b1;
          if (b_v && b_r) begin
            addr_q <= addr_q + 14'h0001;
            if (first_q) begin
              first_q <= 1'b0;
              // The count includes itself, so count - 1 words follow it.
              left_q <= b_d - 8'h01;
              // A refused count halts here, so nothing lands past the image limit.
              if (b_d > BMSL_MAX_IMAGE || b_d == 8'h00) begin
                load_error <= 1'b1;
                st_q <= BMSL_S_DONE;
              end else if (b_d == 8'h01) begin
                core_pc <= BMSL_RAM_ENTRY;
                core_start <= 1'b1;
                st_q <= BMSL_S_RUN;
              end
            end else begin
              left_q <= left_q - 8'h01;
              if (left_q == 8'h01) begin
                core_pc <= BMSL_RAM_ENTRY;
                core_start <= 1'b1;
                st_q <= BMSL_S_RUN;
              end
            end
          end
        end
        BMSL_S_XRST: begin
          addr_q <= BMSL_EP_FIRST;
          st_q <= BMSL_S_PROGRAMMING_LAMP;
        end
        BMSL_S_PROGRAMMING_LAMP: begin
          if (ph_programming_lamp_adv) begin
            if (addr_q == EP_LAST) st_q <= BMSL_S_VRST;
            addr_q <= addr_q + 14'h0001;
          end
        end
        BMSL_S_VRST: begin
          addr_q <= BMSL_EP_FIRST;
          ok_q <= 1'b1;
          st_q <= BMSL_S_VER;
        end
        BMSL_S_VER: begin
          if (ph_programming_lamp_adv) begin
            if (ep_rdata != ext_data) ok_q <= 1'b0;
            if (addr_q == EP_LAST) st_q <= BMSL_S_DONE;
            addr_q <= addr_q + 14'h0001;
          end
        end
        BMSL_S_DONE: st_q <= BMSL_S_DONE;
        BMSL_S_RUN: st_q <= BMSL_S_RUN;
        default: st_q <= BMSL_S_SEL;
      endcase
    end
  end

  // External counter clock: two-cycle step, rising edge in the second half.
  assign ph_programming_lamp_adv = cclk_q;
  always_ff @(posedge core_clk) begin
    if (rst) cclk_q <= 1'b0;
    else if (st_q == BMSL_S_PROGRAMMING_LAMP || st_q == BMSL_S_VER) cclk_q <= !cclk_q;
    else cclk_q <= 1'b0;
  end

  // Counter pins and lamps follow the sequencer; both addresses step together.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_cnt_clk <= 1'b0;
      ext_cnt_rst <= 1'b1;
      programming_lamp <= 1'b0;
      verify_lamp <= 1'b0;
    end else begin
      ext_cnt_clk <= cclk_q;
      ext_cnt_rst <= (st_q == BMSL_S_XRST || st_q == BMSL_S_VRST || st_q == BMSL_S_SEL);
      programming_lamp <= (st_q == BMSL_S_PROGRAMMING_LAMP);
      // DONE is also the halt after a refused download; only the EPROM loader lights it.
      verify_lamp <= (st_q == BMSL_S_DONE) && ok_q
        && (mode == BMSL_EP_PROGRAM || mode == BMSL_EP_VERIFY);
    end
  end

  // Write ports are registered so data pins come from flip-flops.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ram_we <= 1'b0;
      ram_addr <= 14'h0000;
      ram_wdata <= 8'h00;
      ep_we <= 1'b0;
      ep_wdata <= 8'h00;
    end else begin
      ram_we <= b_v && b_r;
      ram_addr <= addr_q;
      ram_wdata <= b_d;
      ep_we <= (st_q == BMSL_S_PROGRAMMING_LAMP) && !cclk_q;
      ep_wdata <= ext_data;
    end
  end
  assign ep_addr = addr_q;

  // Unused source codes fold onto the last slot, so no vector leaves its table.
  assign src_idx = (irq_src > 3'h4) ? 3'h4 : irq_src;

  // Vector redirection; single chip takes vectors from 3FE4 up, the same slots as the EPROM loader.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vec_addr <= 14'h0000;
      vec_in_ram <= 1'b0;
    end else begin
      vec_in_ram <= (mode != BMSL_SINGLE);
      if (mode == BMSL_RAM_JUMP || mode == BMSL_RAM_LOAD) begin
        case (irq_src)
          3'h0: vec_addr <= BMSL_PV_SWI;
          3'h1: vec_addr <= BMSL_PV_IRQ;
          3'h2: vec_addr <= BMSL_PV_CTIMER;
          3'h3: vec_addr <= BMSL_PV_I2C;
          default: vec_addr <= BMSL_PV_PTIMER;
        endcase
      end else if (mode != BMSL_SINGLE) begin
        vec_addr <= BMSL_LDR_VEC_LO + {10'h000, src_idx, 1'b0};
      end else begin
        vec_addr <= BMSL_EP_LAST - 14'h001B + {10'h000, src_idx, 1'b0};
      end
    end
  end

  // Assertions. Most watch the pins that the far side sees, so a failure points
  // at a visible misbehaviour; a few also read sel_q, ok_q, st_q or addr_q.
  a_ram_jump_pc: assert property (@(posedge core_clk) disable iff (rst)
    core_start && mode == BMSL_RAM_JUMP |-> core_pc == 14'h0081)
    else $error("RAM jump did not start at 0081");
  a_single_mode: assert property (@(posedge core_clk) disable iff (rst)
    $rose(sel_q) && !$past(high_voltage_mode_pin) |-> mode == BMSL_SINGLE)
    else $error("Single chip not chosen");
  a_lamps_excl: assert property (@(posedge core_clk) disable iff (rst)
    !(programming_lamp && verify_lamp))
    else $error("Both lamps lit");
  a_verify_fail: assert property (@(posedge core_clk) disable iff (rst)
    !ok_q |-> !verify_lamp)
    else $error("Verify lamp lit after mismatch");
  a_pv_slot: assert property (@(posedge core_clk) disable iff (rst)
    (mode == BMSL_RAM_LOAD && irq_src == 3'h3) |=> vec_addr == 14'h008C)
    else $error("I2C pseudo-vector wrong");
  a_ldr_vec: assert property (@(posedge core_clk) disable iff (rst)
    (mode == BMSL_EP_VERIFY) |=> vec_addr >= 14'h3FE4 && vec_addr <= 14'h3FEF)
    else $error("Loader vector outside reserved ROM");
  a_lockstep: assert property (@(posedge core_clk) disable iff (rst)
    $rose(ext_cnt_clk) |-> addr_q == $past(addr_q) + 14'h0001)
    else $error("Counter clock out of step with address");
  a_load_start: assert property (@(posedge core_clk) disable iff (rst)
    core_start && mode == BMSL_RAM_LOAD
      |-> core_pc == 14'h0081 && $past(st_q == BMSL_S_DL))
    else $error("Download start wrong");
  a_guard_single: assert property (@(posedge core_clk) disable iff (rst)
    $rose(sel_q) && !$past(mode_guard_pin) |-> mode == BMSL_SINGLE)
    else $error("Bootloader entered without guard pin");
  a_image_limit: assert property (@(posedge core_clk) disable iff (rst)
    ram_we |-> ram_addr < BMSL_RAM_BASE + 14'(BMSL_MAX_IMAGE))
    else $error("Download wrote past the image limit");
  a_dl_quiet: assert property (@(posedge core_clk) disable iff (rst)
    $past(st_q == BMSL_S_RUN) |-> !ram_we)
    else $error("RAM written after the last counted byte");
  a_start_pulse: assert property (@(posedge core_clk) disable iff (rst)
    core_start |=> !core_start)
    else $error("Core start held longer than one cycle");
  a_vec_ram_flag: assert property (@(posedge core_clk) disable iff (rst)
    mode == BMSL_RAM_JUMP |=> vec_in_ram)
    else $error("RAM loader vectors not redirected");
  a_cnt_rst_low: assert property (@(posedge core_clk) disable iff (rst)
    ep_we |-> !ext_cnt_rst)
    else $error("Programming while the counter is held in reset");
  a_programming_lamp_lamp_mode: assert property (@(posedge core_clk) disable iff (rst)
    programming_lamp |-> mode == BMSL_EP_PROGRAM)
    else $error("Programming lamp lit outside program mode");
  a_we_lamp: assert property (@(posedge core_clk) disable iff (rst)
    ep_we |-> programming_lamp)
    else $error("EPROM written with the programming lamp dark");
  a_programming_lamp_first: assert property (@(posedge core_clk) disable iff (rst)
    mode == BMSL_EP_VERIFY |-> !ep_we)
    else $error("Program write in verify-only mode");
  c_jump: cover property (@(posedge core_clk) core_start && mode == BMSL_RAM_JUMP);
  c_load: cover property (@(posedge core_clk) core_start && mode == BMSL_RAM_LOAD);
  c_verok: cover property (@(posedge core_clk) verify_lamp);
  c_verbad: cover property (@(posedge core_clk) st_q == BMSL_S_DONE && !ok_q);
  c_refused: cover property (@(posedge core_clk) load_error);
endmodule : bmsl_loader

// ---- verif/bmsl_far_model.sv ----
// Purpose: Far side of the loader: serial host, external counter and memory, on-chip EPROM.
// Assumes: Bench calls send_byte just after a rising core_clk edge.
// Notes: EPROM cells only clear bits, so a missing erase shows up as bad data.
`timescale 1ns/1ps
module bmsl_far_model #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input wire logic core_clk,
  // Serial host
  output logic serial_load_input,
  // External counter and memory
  input wire logic ext_cnt_clk,
  input wire logic ext_cnt_rst,
  output logic [7:0] ext_data,
  // On-chip EPROM array
  input wire logic ep_we,
  input wire logic [13:0] ep_addr,
  input wire logic [7:0] ep_wdata,
  output logic [7:0] ep_rdata
);
  import bmsl_pkg::*;
  logic [13:0] cnt_q;
  logic [7:0] ext_mem [0:16383];
  logic [7:0] chip_mem [0:16383];
  logic line_q = 1'b1;

  // The line idles high between frames.
  assign serial_load_input = line_q;

  // External address counter, reset and clocked only by the device.
  always_ff @(posedge ext_cnt_clk or posedge ext_cnt_rst) begin
    if (ext_cnt_rst) begin
      cnt_q <= 14'h0000;
    end else begin
      cnt_q <= cnt_q + 14'h0001;
    end
  end
  assign ext_data = ext_mem[cnt_q];

  // Programming can only clear bits, as in a real cell.
  always @(posedge core_clk) begin
    if (ep_we === 1'b1) begin
      chip_mem[ep_addr] <= chip_mem[ep_addr] & ep_wdata;
    end
  end
  assign ep_rdata = chip_mem[ep_addr];

  // Erase the array and lay the image out on the device's own map.
  task automatic prepare();
    for (int i = 0; i < 16384; i++) begin
      chip_mem[i] = 8'hFF;
      ext_mem[i] = 8'(i * 37 + 5);
    end
  endtask : prepare

  // One 8N1 frame, LSB first; a zero stop bit models a broken frame.
  task automatic send_byte(input logic [7:0] b, input logic stop_ok);
    logic [9:0] frame;
    frame = {stop_ok, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_q = frame[i];
      repeat (BIT_CYC) @(posedge core_clk);
      #1;
    end
    // A good frame already ends high; only a broken one needs the line back at idle.
    if (!stop_ok) line_q = 1'b1;
  endtask : send_byte
endmodule : bmsl_far_model

// ---- verif/bmsl_loader_bench.sv ----
// Purpose: Self-checking bench for mode selection and both loaders.
// Assumes: Shortened bit time of 16 clocks and a 16-byte EPROM pass.
// Notes: Monitors record RAM, start and EPROM traffic between resets.
`timescale 1ns/1ps
module bmsl_loader_bench;
  import bmsl_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hv = 1'b0, guard = 1'b0, kind = 1'b0, action = 1'b0;
  logic serial_line, ram_we, core_start, vec_in_ram, ext_cnt_clk, ext_cnt_rst;
  logic ep_we, programming_lamp, verify_lamp, load_error;
  logic [2:0] irq_src = 3'h0;
  logic [13:0] ram_addr, core_pc, vec_addr, ep_addr, pc_seen;
  logic [7:0] ram_wdata, ext_data, ep_wdata, ep_rdata;
  logic [7:0] ram_img [0:511];
  bmsl_mode_t mode;
  int fails = 0, n_compared = 0, n_ram = 0, n_start = 0, n_ep = 0;
  logic [13:0] pv [5] = '{BMSL_PV_SWI, BMSL_PV_IRQ, BMSL_PV_CTIMER, BMSL_PV_I2C, BMSL_PV_PTIMER};

  bmsl_loader #(.BIT_CYC(16), .EP_LAST(14'h000F)) dut_u (.core_clk(core_clk), .rst(rst),
    .high_voltage_mode_pin(hv), .mode_guard_pin(guard), .loader_kind_pin(kind),
    .loader_action_pin(action), .serial_load_input(serial_line), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .core_start(core_start), .core_pc(core_pc),
    .mode(mode), .irq_src(irq_src), .vec_addr(vec_addr), .vec_in_ram(vec_in_ram),
    .ext_cnt_clk(ext_cnt_clk), .ext_cnt_rst(ext_cnt_rst), .ext_data(ext_data), .ep_we(ep_we),
    .ep_addr(ep_addr), .ep_wdata(ep_wdata), .ep_rdata(ep_rdata),
    .programming_lamp(programming_lamp), .verify_lamp(verify_lamp), .load_error(load_error));

  bmsl_far_model #(.BIT_CYC(16)) far_u (.core_clk(core_clk), .serial_load_input(serial_line),
    .ext_cnt_clk(ext_cnt_clk), .ext_cnt_rst(ext_cnt_rst), .ext_data(ext_data), .ep_we(ep_we),
    .ep_addr(ep_addr), .ep_wdata(ep_wdata), .ep_rdata(ep_rdata));

  // A 25 ns period gives the 40 MHz core clock.
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  // Straps are set during reset so they are settled at the release edge.
  task automatic apply_reset(input logic h, input logic g, input logic k, input logic a);
    rst = 1'b1;
    hv = h;
    guard = g;
    kind = k;
    action = a;
    step(6);
    n_ram = 0;
    n_start = 0;
    n_ep = 0;
    rst = 1'b0;
    step(2);
  endtask : apply_reset

  // Every EPROM write must carry the external byte at the same count, lamp lit.
  always @(posedge core_clk) begin
    if (ram_we === 1'b1) begin
      ram_img[ram_addr[8:0]] = ram_wdata;
      n_ram++;
    end
    if (core_start === 1'b1) begin
      n_start++;
      pc_seen = core_pc;
    end
    if (ep_we === 1'b1) begin
      n_ep++;
      check("ep_wdata", ep_wdata, far_u.ext_mem[ep_addr]);
      check("ext_count", far_u.cnt_q, ep_addr);
      check("programming_lamp_lamp", programming_lamp, 1'b1);
    end
  end

  task automatic t_single();
    apply_reset(1'b0, 1'b1, 1'b1, 1'b1);
    check("mode", mode, BMSL_SINGLE);
    irq_src = 3'h1;
    step(2);
    check("vec_in_ram", vec_in_ram, 1'b0);
    apply_reset(1'b1, 1'b0, 1'b1, 1'b0);
    check("mode", mode, BMSL_SINGLE);
    $display("single chip test done");
  endtask : t_single

  // Jump straight to RAM, then walk all five interrupt sources.
  task automatic t_ram_jump();
    apply_reset(1'b1, 1'b1, 1'b1, 1'b0);
    step(2);
    check("mode", mode, BMSL_RAM_JUMP);
    check("starts", n_start, 1);
    check("core_pc", pc_seen, BMSL_RAM_ENTRY);
    for (int i = 0; i < 5; i++) begin
      irq_src = 3'(i);
      step(2);
      check("vec_addr", vec_addr, pv[i]);
      check("vec_in_ram", vec_in_ram, 1'b1);
    end
    $display("ram jump test done");
  endtask : t_ram_jump

  // Count 4 plus three bytes; a trailing fifth byte must be ignored.
  task automatic t_ram_load();
    logic [7:0] img [4] = '{8'h04, 8'hA5, 8'h3C, 8'h81};
    apply_reset(1'b1, 1'b1, 1'b1, 1'b1);
    check("mode", mode, BMSL_RAM_LOAD);
    irq_src = 3'h3;
    for (int i = 0; i < 4; i++) begin
      far_u.send_byte(img[i], 1'b1);
    end
    for (int i = 0; i < 60 && n_start == 0; i++) begin
      step(1);
    end
    far_u.send_byte(8'h5A, 1'b1);
    step(10);
    check("ram_writes", n_ram, 4);
    for (int i = 0; i < 4; i++) begin
      check("ram_byte", ram_img[9'h080 + 9'(i)], img[i]);
    end
    check("starts", n_start, 1);
    check("core_pc", pc_seen, BMSL_RAM_ENTRY);
    check("vec_addr", vec_addr, BMSL_PV_I2C);
    $display("ram load test done");
  endtask : t_ram_load

  // A broken stop bit and an oversize count must both be refused.
  task automatic t_load_err();
    apply_reset(1'b1, 1'b1, 1'b1, 1'b1);
    far_u.send_byte(8'h03, 1'b0);
    step(40);
    check("stop_err", load_error, 1'b1);
    check("ram_writes", n_ram, 0);
    apply_reset(1'b1, 1'b1, 1'b1, 1'b1);
    far_u.send_byte(8'hFF, 1'b1);
    step(40);
    check("count_err", load_error, 1'b1);
    check("starts", n_start, 0);
    check("verify_lamp", verify_lamp, 1'b0);
    $display("load error test done");
  endtask : t_load_err

  // Program and verify, verify alone, then verify against a spoiled byte.
  task automatic t_eprom();
    far_u.prepare();
    apply_reset(1'b1, 1'b1, 1'b0, 1'b1);
    check("mode", mode, BMSL_EP_PROGRAM);
    for (int i = 0; i < 400 && verify_lamp !== 1'b1; i++) begin
      step(1);
    end
    check("ep_writes", n_ep, 16);
    check("programming_lamp_lamp", programming_lamp, 1'b0);
    check("verify_lamp", verify_lamp, 1'b1);
    apply_reset(1'b1, 1'b1, 1'b0, 1'b0);
    check("mode", mode, BMSL_EP_VERIFY);
    step(300);
    check("ep_writes", n_ep, 0);
    check("verify_lamp", verify_lamp, 1'b1);
    far_u.chip_mem[5] = ~far_u.ext_mem[5];
    apply_reset(1'b1, 1'b1, 1'b0, 1'b0);
    step(300);
    check("verify_lamp", verify_lamp, 1'b0);
    check("programming_lamp_lamp", programming_lamp, 1'b0);
    $display("eprom loader test done");
  endtask : t_eprom

  // Main sequence.
  initial begin
    t_single();
    t_ram_jump();
    t_ram_load();
    t_load_err();
    t_eprom();
    conclude();
  end

  // The tests need roughly 2000 cycles; give them ten times that.
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    conclude();
  end
endmodule : bmsl_loader_bench
